// ===== rtl/hwerr_defs.svh
/*
 * Constants for the hardware error capture block: register byte addresses,
 * status field positions, reset values and encodings.
 * Assumes it is included by bare name, once per compilation unit or more.
 */
`ifndef HWERR_DEFS_SVH
`define HWERR_DEFS_SVH

// ==========================================================================
// register byte addresses on the wishbone bus
`define FAIL_ADDR_OFS 32'h8000000c
`define FAIL_STAT_OFS 32'h80000010

// ==========================================================================
// status register field positions
`define STAT_EED_BIT 9
`define STAT_HED_BIT 8
`define STAT_TYPE_BIT 7
`define STAT_MOD_HI 6
`define STAT_MOD_LO 3
`define STAT_SIZE_HI 2
`define STAT_SIZE_LO 0
`define STAT_RSVD_W 22

// ==========================================================================
// reset values
`define FAIL_ADDR_RST 32'h00000000
`define STAT_FLAG_RST 1'h0
`define STAT_MOD_RST 4'h0
`define STAT_SIZE_RST 3'h0

// ==========================================================================
// failing module and access size encodings
`define MOD_CODE_INT_FLOAT 4'h0
`define MOD_CODE_PCI_INIT 4'h1
`define MOD_CODE_PCI_TGT 4'h2
`define MOD_CODE_DEBUG_COMM 4'h3
`define SIZE_CODE_BYTE 3'h0
`define SIZE_CODE_HALF 3'h1
`define SIZE_CODE_WORD 3'h2
`define SIZE_CODE_DOUBLE 3'h3

// ==========================================================================
// number of error sources feeding the capture logic
`define ERR_SRC_NUM 5

`endif

// ===== rtl/hwerr_pkg.sv
/*
 * Types for the hardware error capture block: error records, source
 * indices, the wishbone request bundle and the register decode function.
 * Assumes hwerr_defs.svh is on the include path.
 */
`default_nettype none

`include "hwerr_defs.svh"

package hwerr_pkg;

    // ======================================================================
    // encodings
    typedef enum logic [3:0] {
        MOD_INTEGER_OR_FLOAT_UNIT = `MOD_CODE_INT_FLOAT,
        MOD_PCI_INITIATOR = `MOD_CODE_PCI_INIT,
        MOD_PCI_TARGET = `MOD_CODE_PCI_TGT,
        MOD_DEBUG_COMM = `MOD_CODE_DEBUG_COMM
    } fail_module_e;

    typedef enum logic [2:0] {
        SIZE_BYTE = `SIZE_CODE_BYTE,
        SIZE_HALF = `SIZE_CODE_HALF,
        SIZE_WORD = `SIZE_CODE_WORD,
        SIZE_DOUBLE = `SIZE_CODE_DOUBLE
    } fail_size_e;

    // source index; a lower index wins when several fire together
    typedef enum logic [2:0] {
        SRC_BUS_EXC = 3'h0,
        SRC_WRITE_PROT = 3'h1,
        SRC_EXT_EDAC = 3'h2,
        SRC_PCI_INIT = 3'h3,
        SRC_PCI_TGT = 3'h4
    } err_src_idx_e;

    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_ADDR = 2'h1,
        SEL_STAT = 2'h2
    } reg_sel_e;

    // ======================================================================
    // carriers
    typedef struct packed {
        logic [31:0] addr;
        logic is_read;
        logic [3:0] mod_code;
        logic [2:0] size;
    } err_rec_s;

    typedef struct packed {
        logic valid;
        err_rec_s rec;
    } err_src_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // ======================================================================
    // full address decode, shared by the bus port and the read mux
    function automatic reg_sel_e decode_reg(input logic [31:0] adr);
        if (adr == `FAIL_ADDR_OFS) begin
            return SEL_ADDR;
        end else if (adr == `FAIL_STAT_OFS) begin
            return SEL_STAT;
        end
        return SEL_NONE;
    endfunction

endpackage

`default_nettype wire

// ===== rtl/wb_reg_port.sv
/*
 * Classic wishbone slave front end: one wait state, then ack for one cycle.
 * Assumes the master holds its request until it sees ack and then drops
 * cyc/stb for at least one cycle.
 */
`default_nettype none

module wb_reg_port
    import hwerr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus request
    input wire wb_req_s req_i,
    // towards the register file
    output logic ack_o,
    output logic load_o,
    output logic wr_o,
    output reg_sel_e sel_o
);

    typedef struct packed {
        logic ack;
    } port_state_s;

    port_state_s s_r;
    port_state_s s_nxt;
    logic active;

    // ======================================================================
    // handshake
    assign active = req_i.cyc && req_i.stb;

    // ack drops the cycle after it rose, even if the master is slow to drop
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = active && !s_r.ack;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // read data is loaded in the wait cycle, writes land on the ack edge
    assign ack_o = s_r.ack;
    assign load_o = active && !s_r.ack;
    assign wr_o = active && req_i.we && s_r.ack;
    assign sel_o = decode_reg(req_i.adr);

endmodule

`default_nettype wire

// ===== rtl/err_select.sv
/*
 * Fixed-priority selection among the hardware error sources; the lowest
 * source index wins. Purely combinational.
 * Assumes each source presents its record in the cycle its valid is high.
 */
`default_nettype none

module err_select
    import hwerr_pkg::*;
(
    // error sources
    input wire err_src_s [`ERR_SRC_NUM-1:0] src_i,
    // winning record
    output logic any_o,
    output err_rec_s rec_o
);

    logic [`ERR_SRC_NUM:0] blocked;
    logic [`ERR_SRC_NUM-1:0] won;

    // ======================================================================
    // priority chain
    assign blocked[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < `ERR_SRC_NUM; i++) begin : g_prio
            assign won[i] = src_i[i].valid && !blocked[i];
            assign blocked[i+1] = blocked[i] || src_i[i].valid;
        end
    endgenerate

    // one-hot select of the winning record
    always_comb begin
        rec_o = '0;
        for (int k = 0; k < `ERR_SRC_NUM; k++) begin
            if (won[k]) begin
                rec_o = src_i[k].rec;
            end
        end
    end

    assign any_o = blocked[`ERR_SRC_NUM];

endmodule

`default_nettype wire

// ===== rtl/hwerr_capture.sv
/*
 * Hardware error capture: failing access address register and failure
 * status register behind a classic wishbone slave.
 * Assumes error sources give one-cycle (or level) valid strobes with the
 * record alongside, on clk_i, and that software runs the bus.
 */
`default_nettype none

module hwerr_capture
    import hwerr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // error sources
    input wire err_src_s [`ERR_SRC_NUM-1:0] err_src_i,
    input wire logic edac_corr_i,
    // flag levels for the rest of the chip
    output logic hw_err_o,
    output logic corr_err_o
);

    // ======================================================================
    // state
    typedef struct packed {
        logic [31:0] fail_addr;
        logic hed;
        logic eed;
        logic is_read;
        logic [3:0] mod_code;
        logic [2:0] size;
        logic [31:0] rdata;
    } cap_state_s;

    cap_state_s s_r;
    cap_state_s s_nxt;

    wb_req_s req;
    logic bus_load;
    logic bus_wr;
    reg_sel_e bus_sel;
    logic err_any;
    err_rec_s err_rec;

    // ======================================================================
    // helpers

    // apply only the enabled byte lanes of a write onto an old word
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // status image as software sees it; upper bits stay zero
    function automatic logic [31:0] stat_image(input cap_state_s st);
        return {{`STAT_RSVD_W{1'b0}}, st.eed, st.hed,
                st.is_read, st.mod_code, st.size};
    endfunction

    // ======================================================================
    // bus front end
    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we = wb_we_i;
    assign req.adr = wb_adr_i;
    assign req.sel = wb_sel_i;
    assign req.dat = wb_dat_i;

    wb_reg_port u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_i(req),
        .ack_o(wb_ack_o),
        .load_o(bus_load),
        .wr_o(bus_wr),
        .sel_o(bus_sel)
    );

    // ======================================================================
    // error source priority
    err_select u_select (
        .src_i(err_src_i),
        .any_o(err_any),
        .rec_o(err_rec)
    );

    // ======================================================================
    // next state
    // software effects are worked out first, hardware events last, so an
    // event in the same cycle as a clear always wins
    always_comb begin
        logic [31:0] img;
        img = '0;
        s_nxt = s_r;

        // address writes only count while a capture is held
        if (bus_wr && bus_sel == SEL_ADDR && s_r.hed) begin
            s_nxt.fail_addr = merge_lanes(s_r.fail_addr, req.dat, req.sel);
        end

        if (bus_wr && bus_sel == SEL_STAT) begin
            img = merge_lanes(stat_image(s_r), req.dat, req.sel);
            // field writes are discarded unless a capture is held
            if (s_r.hed) begin
                s_nxt.is_read = img[`STAT_TYPE_BIT];
                s_nxt.mod_code = img[`STAT_MOD_HI:`STAT_MOD_LO];
                s_nxt.size = img[`STAT_SIZE_HI:`STAT_SIZE_LO];
            end
            // a zero clears a flag; writing one leaves it as it is
            if (!img[`STAT_EED_BIT]) begin
                s_nxt.eed = 1'b0;
            end
            if (!img[`STAT_HED_BIT]) begin
                s_nxt.hed = 1'b0;
            end
        end

        // correctable memory errors are recorded regardless of hed
        if (edac_corr_i) begin
            s_nxt.eed = 1'b1;
        end

        // capture only when no earlier capture survives this cycle
        if (err_any && !s_nxt.hed) begin
            s_nxt.hed = 1'b1;
            s_nxt.fail_addr = err_rec.addr;
            s_nxt.is_read = err_rec.is_read;
            s_nxt.mod_code = err_rec.mod_code;
            s_nxt.size = err_rec.size;
        end

        // read data is sampled in the wait cycle, before any write lands;
        // fields show last capture even when hed is clear
        if (bus_load) begin
            unique case (bus_sel)
                SEL_ADDR: s_nxt.rdata = s_r.fail_addr;
                SEL_STAT: s_nxt.rdata = stat_image(s_r);
                SEL_NONE: s_nxt.rdata = '0;
            endcase
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r.fail_addr <= `FAIL_ADDR_RST;
            s_r.hed <= `STAT_FLAG_RST;
            s_r.eed <= `STAT_FLAG_RST;
            s_r.is_read <= `STAT_FLAG_RST;
            s_r.mod_code <= `STAT_MOD_RST;
            s_r.size <= `STAT_SIZE_RST;
            s_r.rdata <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // outputs, all from flip-flops
    assign wb_dat_o = s_r.rdata;
    assign hw_err_o = s_r.hed;
    assign corr_err_o = s_r.eed;

endmodule

`default_nettype wire

// ===== verif/hwerr_capture_monitor.sv
/*
 * Checker for the hardware error capture block, bound to its top.
 * Assumes the port list of hwerr_capture and one clock domain.
 */
`default_nettype none
`include "hwerr_defs.svh"

module hwerr_capture_monitor
    import hwerr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // error side
    input wire err_src_s [`ERR_SRC_NUM-1:0] err_src_i,
    input wire logic edac_corr_i,
    input wire logic hw_err_o,
    input wire logic corr_err_o
);
    // ======================================================================
    // helpers
    logic any_v;
    logic st_rd;
    logic st_wr;

    // any source firing this cycle
    always_comb begin
        any_v = 1'b0;
        for (int i = 0; i < `ERR_SRC_NUM; i++) begin
            any_v = any_v | err_src_i[i].valid;
        end
    end

    // status read taken, status write with the flag byte landing
    assign st_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o & (wb_adr_i == `FAIL_STAT_OFS);
    assign st_wr = wb_ack_o & wb_we_i & wb_sel_i[1] & (wb_adr_i == `FAIL_STAT_OFS);

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ======================================================================
    // properties
    ack_in_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    hed_set_a: assert property (any_v |=> hw_err_o)
        else $error("error source did not set flag");
    hed_cause_a: assert property ($rose(hw_err_o) |-> $past(any_v))
        else $error("flag rose without source");
    hed_sticky_a: assert property (
        $fell(hw_err_o) |-> $past(st_wr & ~wb_dat_i[8]) || $past(rst_i))
        else $error("error flag cleared by hardware");
    eed_set_a: assert property (edac_corr_i |=> corr_err_o)
        else $error("correctable error not flagged");
    eed_cause_a: assert property ($rose(corr_err_o) |-> $past(edac_corr_i))
        else $error("correctable flag rose without cause");
    eed_sticky_a: assert property (
        $fell(corr_err_o) |-> $past(st_wr & ~wb_dat_i[9]) || $past(rst_i))
        else $error("correctable flag cleared by hardware");
    rsvd_zero_a: assert property (
        wb_ack_o && $past(st_rd) |-> wb_dat_o[31:10] == 22'h0)
        else $error("reserved status bits not zero");
    flag_read_a: assert property (
        wb_ack_o && $past(st_rd) |-> wb_dat_o[9:8] == $past({corr_err_o, hw_err_o}))
        else $error("status flags read wrong");
endmodule

bind hwerr_capture hwerr_capture_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .err_src_i(err_src_i), .edac_corr_i(edac_corr_i), .hw_err_o(hw_err_o),
    .corr_err_o(corr_err_o));

`default_nettype wire

// ===== verif/err_source_model.sv
/*
 * Model of the on-chip error detectors feeding the capture block.
 * Assumes the bench raises go bits for exactly one clock cycle.
 */
`default_nettype none
`include "hwerr_defs.svh"

module err_source_model
    import hwerr_pkg::*;
(
    // request from the bench
    input wire logic [4:0] go_i,
    input wire err_rec_s rec_i,
    // towards the capture block
    output var err_src_s [`ERR_SRC_NUM-1:0] src_o
);
    // each source tags the address with its index; a quiet source shows
    // a scrambled record, since detectors promise nothing while idle
    always_comb begin
        for (int i = 0; i < `ERR_SRC_NUM; i++) begin
            src_o[i].valid = go_i[i];
            src_o[i].rec = go_i[i] ? rec_i : ~rec_i;
            src_o[i].rec.addr = (go_i[i] ? rec_i.addr : ~rec_i.addr) ^ 32'(i);
        end
    end
endmodule

`default_nettype wire

// ===== verif/test_hwerr_capture.sv
/*
 * Self-checking bench for the hardware error capture block.
 * Assumes the design, package, header and the source model are compiled first.
 */
`default_nettype none
`include "hwerr_defs.svh"

module test_hwerr_capture
    import hwerr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ======================================================================
    // signals
    logic clk_i, rst_i, cyc, stb, we, ack, edac, hed, eed;
    logic [3:0] sel;
    logic [4:0] go, m;
    logic [31:0] adr, dat, dat_o, r, exp_a, seed;
    err_rec_s cur, rec, rec2;
    err_src_s [`ERR_SRC_NUM-1:0] src;
    int n_mismatch = 0;
    int compares = 0;
    localparam logic [31:0] st = `FAIL_STAT_OFS;
    localparam logic [31:0] ad = `FAIL_ADDR_OFS;

    hwerr_capture i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .err_src_i(src), .edac_corr_i(edac), .hw_err_o(hed),
        .corr_err_o(eed));
    err_source_model i_src (.go_i(go), .rec_i(cur), .src_o(src));

    // ======================================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] st_exp(input logic e, input logic h, input err_rec_s q);
        return {22'h0, e, h, q.is_read, q.mod_code, q.size};
    endfunction

    // lowest firing source wins
    function automatic logic [31:0] win(input logic [4:0] v);
        for (int i = 0; i < 5; i++) begin
            if (v[i]) begin
                return 32'(i);
            end
        end
        return 32'h0;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // flag levels on the side outputs, as they stand before this edge
    task automatic cmp_flags(input logic e, input logic h);
        cmp({30'h0, eed, hed}, {30'h0, e, h});
    endtask

    // one classic cycle; ack and read data are taken at the rising edge
    // that sees ack high, and only then is the request released
    task automatic bus(input logic w, input logic [31:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        adr <= ~a;
        dat <= ~d;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hf, 32'h0);
        cmp(r, exp);
    endtask

    task automatic fire(input logic [4:0] v, input logic e, input err_rec_s q);
        @(posedge clk_i);
        go <= v;
        edac <= e;
        cur <= q;
        @(posedge clk_i);
        go <= 5'h0;
        edac <= 1'b0;
    endtask

    task automatic close_out();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ======================================================================
    // clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        close_out();
    end

    // ======================================================================
    // main sequence
    initial begin
        {cyc, stb, we, edac, go, sel, adr, dat, cur} = '0;
        seed = 32'h147f85e0;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(st, 32'h0);
        cmp_flags(1'b0, 1'b0);
        bus(1'b1, st, 4'hf, 32'h0);
        bus(1'b1, ad, 4'hf, 32'h5a5a5a5a);
        bus(1'b1, st, 4'h1, 32'hff);
        rd(ad, 32'h0);
        rd(st, 32'h0);
        rd(32'h80000014, 32'h0);
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            rec.addr = seed;
            seed = xs(seed);
            rec.is_read = seed[0];
            rec.mod_code = 4'(k % 4);
            rec.size = 3'((k / 4) % 4);
            m = (seed[5:1] == 5'h0) ? 5'h1 : seed[5:1];
            fire(m, seed[6], rec);
            exp_a = rec.addr ^ win(m);
            rd(ad, exp_a);
            rd(st, st_exp(seed[6], 1'b1, rec));
            cmp_flags(seed[6], 1'b1);
            // a later error must leave the capture alone
            rec2 = rec;
            rec2.addr = ~rec.addr;
            rec2.is_read = ~rec.is_read;
            fire(5'h1f, 1'b1, rec2);
            rd(ad, exp_a);
            rd(st, st_exp(1'b1, 1'b1, rec));
            cmp_flags(1'b1, 1'b1);
            // flag byte untouched by a field-only write of the captured values
            bus(1'b1, st, 4'h1, {24'h0, rec.is_read, rec.mod_code, rec.size});
            rd(st, st_exp(1'b1, 1'b1, rec));
            bus(1'b1, st, 4'h2, 32'h0);
            rd(st, st_exp(1'b0, 1'b0, rec));
            cmp_flags(1'b0, 1'b0);
            bus(1'b1, ad, 4'hf, ~exp_a);
            bus(1'b1, st, 4'h1, 32'hff);
            rd(ad, exp_a);
            rd(st, st_exp(1'b0, 1'b0, rec));
        end
        close_out();
    end
endmodule

`default_nettype wire
